// File: core/essr_pkg.sv
// package: constants and carrier types of the eighteen stage shift register
// Functional notes
// - four sections, two of four and two of five stages, one shared clock
// - each four-stage section has its own serial input, output from last stage
// - each five-stage section has its own input, outputs from stages four and five
// - while hold_shift is low, on each falling shift clock edge the first stage takes the serial input
// - on that same edge every stage takes its predecessor's old value
// - sections chain externally, last output to next input, up to eighteen bits
package essr_pkg;

    localparam int SHORT_LEN   = 4;
    localparam int LONG_LEN    = 5;
    localparam int TOTAL_LEN   = 2 * SHORT_LEN + 2 * LONG_LEN;
    localparam int TAP_STAGE   = 3;
    localparam int SECTIONS    = 4;
    localparam int FIFO_DEPTH  = 8;
    localparam logic CLK_IDLE  = 1'h0;

    // one sample of the four serial inputs, taken at a falling shift edge
    typedef struct packed {
        logic serial_in_section_a;
        logic serial_in_section_b;
        logic serial_in_section_c;
        logic serial_in_section_d;
    } essr_ser_s;

    typedef struct packed {
        logic last_stage_out_a;
        logic last_stage_out_b;
        logic fourth_stage_out_c;
        logic fifth_stage_out_c;
        logic fourth_stage_out_d;
        logic fifth_stage_out_d;
    } essr_out_s;

endpackage

// File: core/essr_fifo.sv
// file: parameterised valid/ready fifo used in the shift data path
`timescale 1ns/1ps
`default_nettype none

module essr_fifo #(
    parameter int WIDTH = 4,
    parameter int DEPTH = 8
) (
    input  wire logic             clock,
    input  wire logic             reset,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    logic [AW:0]      next_wr_ptr;
    logic [AW:0]      next_rd_ptr;
    logic             push;
    logic             pop;
    logic             full;
    logic             empty;

    always_comb begin
        full        = (wr_ptr[AW] != rd_ptr[AW]) &&
                      (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
        empty       = (wr_ptr == rd_ptr);
        in_ready    = !full;
        out_valid   = !empty;
        out_data    = mem[rd_ptr[AW-1:0]];
        push        = in_valid && !full;
        pop         = out_ready && !empty;
        next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
        end
    end

    // storage is data only and needs no reset
    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end

endmodule // essr_fifo
`default_nettype wire

// File: core/essr_top.sv
// file: eighteen stage serial shift register in four sections
`timescale 1ns/1ps
`default_nettype none

module essr_top (
    input  wire logic               clock,
    input  wire logic               reset,
    input  wire logic               shift_clock_in,
    input  wire essr_pkg::essr_ser_s serial_in,
    input  wire logic               hold_shift,
    output logic                    shift_ready,
    output essr_pkg::essr_out_s     stage_out
);
    import essr_pkg::*;

    logic                 prev_clk;
    logic                 next_prev_clk;
    logic                 fall;
    logic                 word_valid;
    logic                 word_ready;
    logic [SECTIONS-1:0]  word_bits;
    essr_ser_s            word;
    logic                 step;
    logic [4:0]           fill_count;
    logic [4:0]           next_fill_count;

    logic [SHORT_LEN-1:0] sec_a;
    logic [SHORT_LEN-1:0] sec_b;
    logic [LONG_LEN-1:0]  sec_c;
    logic [LONG_LEN-1:0]  sec_d;
    logic [SHORT_LEN-1:0] next_sec_a;
    logic [SHORT_LEN-1:0] next_sec_b;
    logic [LONG_LEN-1:0]  next_sec_c;
    logic [LONG_LEN-1:0]  next_sec_d;

    // falling edge of the shift clock, seen in the system clock
    always_comb begin
        next_prev_clk = shift_clock_in;
        fall          = prev_clk && !shift_clock_in;
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            prev_clk <= CLK_IDLE;
        end else begin
            prev_clk <= next_prev_clk;
        end
    end

    // each falling edge queues one sample of all four inputs together; an edge that arrives while the queue is full is dropped
    essr_fifo #(
        .WIDTH (SECTIONS),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clock     (clock),
        .reset     (reset),
        .in_valid  (fall),
        .in_ready  (shift_ready),
        .in_data   (serial_in),
        .out_valid (word_valid),
        .out_ready (word_ready),
        .out_data  (word_bits)
    );

    always_comb begin
        word       = essr_ser_s'(word_bits);
        word_ready = !hold_shift;
        step       = word_valid && word_ready;
    end

    // stage 0 is the first stage; contents move toward higher indices
    function automatic logic [SHORT_LEN-1:0] shift_short(
        input logic [SHORT_LEN-1:0] stages,
        input logic                 data_in
    );
        return {stages[SHORT_LEN-2:0], data_in};
    endfunction

    function automatic logic [LONG_LEN-1:0] shift_long(
        input logic [LONG_LEN-1:0] stages,
        input logic                data_in
    );
        return {stages[LONG_LEN-2:0], data_in};
    endfunction

    // four-stage sections
    always_comb begin
        next_sec_a = sec_a;
        next_sec_b = sec_b;
        if (step) begin
            next_sec_a = shift_short(sec_a, word.serial_in_section_a);
            next_sec_b = shift_short(sec_b, word.serial_in_section_b);
        end
    end

    // the stages have no reset: contents hold until shifted in
    always_ff @(posedge clock) begin
        sec_a <= next_sec_a;
        sec_b <= next_sec_b;
    end

    // five-stage sections
    always_comb begin
        next_sec_c = sec_c;
        next_sec_d = sec_d;
        if (step) begin
            next_sec_c = shift_long(sec_c, word.serial_in_section_c);
            next_sec_d = shift_long(sec_d, word.serial_in_section_d);
        end
    end

    always_ff @(posedge clock) begin
        sec_c <= next_sec_c;
        sec_d <= next_sec_d;
    end

    // applied shifts since reset, saturating at the full chained length
    always_comb begin
        next_fill_count = fill_count;
        if (step && fill_count < 5'(TOTAL_LEN)) begin
            next_fill_count = fill_count + 5'h01;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            fill_count <= 5'h00;
        end else begin
            fill_count <= next_fill_count;
        end
    end

    always_comb begin
        stage_out.last_stage_out_a   = sec_a[SHORT_LEN-1];
        stage_out.last_stage_out_b   = sec_b[SHORT_LEN-1];
        stage_out.fourth_stage_out_c = sec_c[TAP_STAGE];
        stage_out.fifth_stage_out_c  = sec_c[LONG_LEN-1];
        stage_out.fourth_stage_out_d = sec_d[TAP_STAGE];
        stage_out.fifth_stage_out_d  = sec_d[LONG_LEN-1];
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);

    first_stage_a: assert property (
        step |=> sec_a[0] == $past(word.serial_in_section_a)
              && sec_b[0] == $past(word.serial_in_section_b)
              && sec_c[0] == $past(word.serial_in_section_c)
              && sec_d[0] == $past(word.serial_in_section_d))
        else $error("first stage missed the serial input");

    shift_advance_a: assert property (
        step |=> sec_a[SHORT_LEN-1:1] === $past(sec_a[SHORT_LEN-2:0])
              && sec_b[SHORT_LEN-1:1] === $past(sec_b[SHORT_LEN-2:0])
              && sec_c[LONG_LEN-1:1] === $past(sec_c[LONG_LEN-2:0])
              && sec_d[LONG_LEN-1:1] === $past(sec_d[LONG_LEN-2:0]))
        else $error("stages did not advance by one place");

    shift_hold_a: assert property (
        !step |=> $stable(sec_a) && $stable(sec_b)
               && $stable(sec_c) && $stable(sec_d))
        else $error("stages moved without a shift");

    edge_queue_a: assert property (
        $fell(shift_clock_in) && !$past(reset) && shift_ready
            |=> word_valid)
        else $error("falling edge was not queued");

    edge_drop_a: assert property (
        fall && !shift_ready && hold_shift |=> !shift_ready)
        else $error("full queue accepted a falling edge");

    queue_hold_a: assert property (
        hold_shift && word_valid |=> word_valid)
        else $error("queued edge lost while shifting was held");

    short_out_a: assert property (
        step ##1 step |=> stage_out.last_stage_out_a == $past(sec_a[2]))
        else $error("four stage output not from last stage");

    long_taps_a: assert property (
        step |=> stage_out.fifth_stage_out_c === $past(sec_c[TAP_STAGE])
              && stage_out.fourth_stage_out_d === $past(sec_d[2]))
        else $error("five stage taps misplaced");

    long_taps_d_a: assert property (
        step |=> stage_out.fifth_stage_out_d === $past(sec_d[TAP_STAGE])
              && stage_out.fourth_stage_out_c === $past(sec_c[2]))
        else $error("second five stage taps misplaced");

    short_out_b_a: assert property (
        step |=> stage_out.last_stage_out_b === $past(sec_b[SHORT_LEN-2]))
        else $error("second four stage output not from last stage");

    output_hold_a: assert property (
        !step |=> $stable(stage_out))
        else $error("outputs changed without a shift");

    chain_depth_a: assert property (
        step[*4] |=> stage_out.last_stage_out_a
                     == $past(word.serial_in_section_a, 4))
        else $error("bit did not reach section end in four shifts");

    chain_b_depth_a: assert property (
        step[*4] |=> stage_out.last_stage_out_b
                     === $past(word.serial_in_section_b, 4))
        else $error("bit did not reach second section end in four shifts");

    chain_long_a: assert property (
        step[*5] |=> stage_out.fifth_stage_out_c
                     === $past(word.serial_in_section_c, 5))
        else $error("bit did not reach five stage end in five shifts");

    shift_seen_c: cover property (step ##1 step ##1 step);
    fifo_full_c: cover property (!shift_ready);
    hold_busy_c: cover property (hold_shift && word_valid);
    drain_run_c: cover property (step[*4]);
    fill_done_c: cover property (fill_count == 5'(TOTAL_LEN));

endmodule // essr_top
`default_nettype wire

// File: tb/essr_src.sv
// upstream model: drives the shift clock and the four serial data lines
`timescale 1ns/1ps
`default_nettype none

module essr_src (
    input  wire logic                clock,
    input  wire logic                chain,
    input  wire essr_pkg::essr_out_s stage_out,
    output logic                     shift_clock_in,
    output essr_pkg::essr_ser_s      serial_in
);
    import essr_pkg::*;
    logic [3:0] word = 4'h0;

    initial shift_clock_in = CLK_IDLE;

    // chained sections are fed from the previous section's last stage
    always_comb begin
        serial_in = word;
        if (chain) begin
            serial_in.serial_in_section_b = stage_out.last_stage_out_a;
            serial_in.serial_in_section_c = stage_out.last_stage_out_b;
            serial_in.serial_in_section_d = stage_out.fifth_stage_out_c;
        end
    end

    // one high, then a falling edge with data; data is scrambled after hold
    task automatic shift(input logic [3:0] d);
        @(negedge clock);
        shift_clock_in = 1'h1;
        @(negedge clock);
        shift_clock_in = 1'h0;
        word = d;
        @(negedge clock);
        word = ~d;
    endtask
endmodule // essr_src
`default_nettype wire

// File: tb/tb.sv
// testbench: self-checking run of the eighteen stage shift register
`timescale 1ns/1ps
`default_nettype none

module tb;
    import essr_pkg::*;
    logic       clock = 1'h0;
    logic       reset = 1'h1;
    logic       hold_shift = 1'h0;
    logic       chain = 1'h0;
    logic       shift_clock_in;
    logic       shift_ready;
    essr_ser_s  serial_in;
    essr_out_s  stage_out;
    essr_out_s  snap;
    logic [3:0] ra, rb;
    logic [4:0] rc, rd;
    int         n_errors = 0;
    int         cmp_count = 0;

    essr_top dut_u (.clock(clock), .reset(reset),
        .shift_clock_in(shift_clock_in), .serial_in(serial_in),
        .hold_shift(hold_shift), .shift_ready(shift_ready),
        .stage_out(stage_out));
    essr_src src_u (.clock(clock), .chain(chain), .stage_out(stage_out),
        .shift_clock_in(shift_clock_in), .serial_in(serial_in));

    initial forever #2.5 clock = ~clock;

    task automatic chk(input string what, input logic [5:0] exp, got);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s exp %h got %h", what, exp, got);
        end
    endtask

    function automatic logic [5:0] ref_out();
        return {ra[3], rb[3], rc[3], rc[4], rd[3], rd[4]};
    endfunction

    // one shift through the model, reference updated alongside
    task automatic sh(input logic [3:0] d, input logic look);
        logic a3, b3, c4;
        a3 = ra[3];
        b3 = rb[3];
        c4 = rc[4];
        src_u.shift(d);
        ra = {ra[2:0], d[3]};
        rb = {rb[2:0], chain ? a3 : d[2]};
        rc = {rc[3:0], chain ? b3 : d[1]};
        rd = {rd[3:0], chain ? c4 : d[0]};
        if (look) begin
            @(negedge clock);
            chk("stage_out", ref_out(), stage_out);
        end
    endtask

    task automatic t_parallel();
        for (int i = 0; i < 14; i++) begin
            sh(4'(i * 7 + 3), i >= 5);
        end
        $display("test parallel done");
    endtask

    task automatic t_chain();
        chain = 1'h1;
        for (int i = 0; i < 20; i++) sh(4'(i * 5 + 9), 1'h1);
        chain = 1'h0;
        $display("test chain done");
    endtask

    task automatic t_hold();
        hold_shift = 1'h1;
        snap = stage_out;
        for (int i = 0; i < 8; i++) begin
            sh(4'(i * 3 + 1), 1'h0);
            chk("shift_ready", 6'(i < 7), 6'(shift_ready));
        end
        src_u.shift(4'hF);
        chk("held stage_out", snap, stage_out);
        hold_shift = 1'h0;
        repeat (20) @(negedge clock);
        chk("drained", ref_out(), stage_out);
        chk("shift_ready", 6'h01, 6'(shift_ready));
        $display("test hold done");
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    initial begin
        repeat (4) @(negedge clock);
        reset = 1'h0;
        t_parallel();
        t_chain();
        t_hold();
        print_verdict();
    end

    initial begin
        repeat (3000) @(posedge clock);
        n_errors++;
        print_verdict();
    end
endmodule // tb
`default_nettype wire
